// file: bench/spc_host.sv
// host model: hands completed serial words and read requests to the bank
`timescale 1ns/1ps
module spc_host (
    // clock
    input  wire logic       sys_clk,
    // word and read-back port
    output logic            wrValid = 1'b0,
    output logic [15:0]     wrWord = 16'h0000,
    output logic            rdReq = 1'b0,
    output logic            rdBank = 1'b0,
    output logic [2:0]      rdAddr = 3'h0,
    input  wire logic       rdValid,
    input  wire logic [8:0] rdData
);
    // random idle gaps make the host answer both promptly and slowly
    task automatic wr(input logic bank, input logic [2:0] code, input logic [8:0] data);
        repeat ($urandom_range(0, 2)) @(posedge sys_clk);
        @(posedge sys_clk);
        #1 wrValid = 1'b1;
        wrWord = {2'h0, bank, code, 1'b0, data};
        @(posedge sys_clk);
        #1 wrValid = 1'b0;
        wrWord = ~wrWord;
    endtask
    task automatic rd(input logic bank, input logic [2:0] addr, output logic [9:0] got);
        @(posedge sys_clk);
        #1 rdReq = 1'b1;
        rdBank = bank;
        rdAddr = addr;
        @(posedge sys_clk);
        #1 rdReq = 1'b0;
        rdAddr = ~addr;
        got = {rdValid, rdData};
    endtask
endmodule

// file: bench/test_switch_protection_config.sv
// self-checking bench for the switch protection configuration bank
`timescale 1ns/1ps
module test_switch_protection_config;
    import spc_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, logicSupplyLow = 1'b0, wrValid, rdReq, rdBank, rdValid;
    logic [15:0] wrWord;
    logic [2:0]  rdAddr;
    logic [8:0]  rdData;
    logic [1:0]  loadProfileConfig = 2'h0, retryAttempt = 2'h0, retryCountClear = 2'h0, ocWindowActive = 2'h0;
    logic [1:0]  lowLevel0, lowLevel1, motorWindowCode0, motorWindowCode1, retryPeriod0, retryPeriod1;
    logic [9:0]  pwmDivider0, pwmDivider1;
    logic [1:0]  clockInternal, senseLowRatio, highWindow2, middleWindow2, upperThrLow, middleThrLow;
    logic [1:0]  offsetAdd, retryEnabled, retryAllowed, retryFull, senseAvailable;
    logic        pwmStartBoth, parallelMode, trackHoldEnable, watchdogEnable, failSafeRequest, overvoltageEnable;
    spc_sense_t  senseSelect;
    int          fails = 0, comparisons = 0, cycles = 0, oc[2], rt[2], gc = 0;
    spc_config_bank uut (.sys_clk, .rst_n, .wrValid, .wrWord, .rdReq, .rdBank, .rdAddr, .rdValid, .rdData,
        .loadProfileConfig, .retryAttempt, .retryCountClear, .ocWindowActive, .logicSupplyLow, .lowLevel0,
        .lowLevel1, .pwmDivider0, .pwmDivider1, .clockInternal, .senseLowRatio, .highWindow2, .middleWindow2,
        .motorWindowCode0, .motorWindowCode1, .upperThrLow, .middleThrLow, .offsetAdd, .retryPeriod0,
        .retryPeriod1, .retryEnabled, .retryAllowed, .retryFull, .senseAvailable, .pwmStartBoth, .parallelMode,
        .trackHoldEnable, .watchdogEnable, .failSafeRequest, .overvoltageEnable, .senseSelect);
    spc_host host (.sys_clk, .wrValid, .wrWord, .rdReq, .rdBank, .rdAddr, .rdValid, .rdData);
    // ============================================================
    // clock, timeout and checking
    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (fails == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // channel 1 follows bank 0 and profile 0 while paralleled; retry counters stay empty here
    task automatic chk_chan(input int c);
        int b, p, o, r;
        logic [15:0] g;
        b = gc[6] ? 0 : c;
        p = loadProfileConfig[b];
        o = oc[b];
        r = rt[b];
        g = c ? {lowLevel1, pwmDivider1, motorWindowCode1, retryPeriod1}
              : {lowLevel0, pwmDivider0, motorWindowCode0, retryPeriod0};
        chk({g, clockInternal[c], senseLowRatio[c], highWindow2[c], middleWindow2[c], upperThrLow[c],
             middleThrLow[c], offsetAdd[c], retryEnabled[c], retryAllowed[c], retryFull[c], senseAvailable[c]},
            {o[8] ? (o[0] ? 2'h2 : 2'h1) : 2'h0, o[7] ? 10'h200 : 10'h100, p ? o[4:3] : 2'h0, r[3:2], o[6],
             o[5], !p & o[4], !p & o[3], o[2], !p & o[1], r[8], p == r[0], p == r[0], 1'b0,
             !ocWindowActive[c]});
    endtask
    task automatic chk_glob();
        spc_sense_t s;
        s = gc[2:1] == 0 ? SENSE_OFF : gc[2:1] == 2 ? SENSE_CH1 : gc[2:1] == 3 ? SENSE_TEMP
          : (oc[0][8] && gc[6]) ? SENSE_SUM : SENSE_CH0;
        chk({pwmStartBoth, parallelMode, trackHoldEnable, watchdogEnable, failSafeRequest, overvoltageEnable,
             senseSelect}, {gc[8] & gc[7], gc[6], gc[5], !gc[4], gc[3] & logicSupplyLow, !gc[0], s});
    endtask
    // ============================================================
    // main sequence
    initial begin
        logic [9:0] rv;
        int bank, b, code, data;
        void'($urandom(98));
        repeat (12) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk_chan(0);
        chk_glob();
        for (int i = 0; i < 60; i++) begin
            bank = $urandom_range(0, 1);
            code = $urandom_range(4, 6);
            data = $urandom_range(0, 511);
            loadProfileConfig = 2'($urandom_range(0, 3));
            ocWindowActive = 2'($urandom_range(0, 3));
            logicSupplyLow = 1'($urandom_range(0, 1));
            host.wr(1'(bank), 3'(code), 9'(data));
            b = gc[6] ? 0 : bank;
            if (code == 4) oc[b] = data;
            else if (code == 5) rt[b] = data;
            else gc = data;
            repeat (3) @(posedge sys_clk);
            #1 chk_chan(0);
            chk_chan(1);
            chk_glob();
            host.rd(1'(bank), 3'(code), rv);
            b = gc[6] ? 0 : bank;
            chk(rv, {1'b1, 9'(code == 4 ? oc[b] : code == 5 ? rt[b] & 'h10F : gc)});
        end
        host.wr(1'b1, 3'h7, 9'h1FF);
        host.rd(1'b1, 3'h7, rv);
        chk(rv, 10'h200);
        host.wr(1'b0, 3'h6, 9'h000);
        host.wr(1'b0, 3'h5, 9'h100);
        host.wr(1'b1, 3'h5, 9'h100);
        gc = 0;
        loadProfileConfig = 2'h0;
        retryAttempt = 2'h3;
        repeat (15) @(posedge sys_clk);
        #1 retryAttempt = 2'h0;
        ocWindowActive = ~ocWindowActive;
        host.rd(1'b0, 3'h5, rv);
        chk(rv, 10'h3F0);
        host.rd(1'b1, 3'h5, rv);
        chk(rv, 10'h3F0);
        chk({retryFull[0], retryAllowed[0]}, 2'h1);
        retryAttempt = 2'h1;
        repeat (3) @(posedge sys_clk);
        #1 retryAttempt = 2'h0;
        repeat (2) @(posedge sys_clk);
        #1 chk({retryFull[0], retryAllowed[0]}, 2'h2);
        host.wr(1'b0, 3'h5, 9'h102);
        repeat (3) @(posedge sys_clk);
        #1 chk({retryFull[0], retryAllowed[0]}, 2'h3);
        retryCountClear = 2'h1;
        @(posedge sys_clk);
        #1 retryCountClear = 2'h0;
        repeat (2) @(posedge sys_clk);
        #1 chk({retryFull[0], retryAllowed[0]}, 2'h1);
        // mid-run reset must clear stored settings and both retry counters
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        oc = '{default: 0};
        rt = '{default: 0};
        repeat (2) @(posedge sys_clk);
        #1 chk_chan(0);
        chk_chan(1);
        chk_glob();
        host.rd(1'b1, 3'h5, rv);
        chk(rv, 10'h200);
        stop_test();
    end
endmodule

// file: verilog/spc_chan_decode.sv
// per-channel decode of overcurrent and retry settings plus retry counter
`timescale 1ns/1ps
module spc_chan_decode
    import spc_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // configuration
    input  wire logic [8:0] ocCfg,
    input  wire logic [8:0] rtCfg,
    input  wire logic       loadProfile,
    // retry events
    input  wire logic       retryAttempt,
    input  wire logic       retryCountClear,
    input  wire logic       ocWindowActive,
    // decoded outputs
    output logic [1:0]      lowLevel,
    output logic [9:0]      pwmDivider,
    output logic            clockInternal,
    output logic            senseLowRatio,
    output logic            highWindow2,
    output logic            middleWindow2,
    output logic [1:0]      motorWindowCode,
    output logic            upperThrLow,
    output logic            middleThrLow,
    output logic            offsetAdd,
    output logic [1:0]      retryPeriod,
    output logic            retryEnabled,
    output logic            retryAllowed,
    output logic            retryFull,
    output logic [4:0]      retryCount,
    output logic            senseAvailable
);
    // ============================================================
    // combinational decode
    wire       isMotor   = (loadProfile == PROFILE_MOTOR);
    wire [1:0] lowNext   = !ocCfg[OC_HIGH_RANGE] ? LOW_LEVEL_HIGHEST :
                           (ocCfg[OC_LOW_THR] ? LOW_LEVEL_LOWEST : LOW_LEVEL_MIDDLE);
    wire       enNext    = isMotor ? rtCfg[RT_CONTROL] : !rtCfg[RT_CONTROL];
    wire       fullNow   = (retryCount >= RETRY_LIMIT);
    wire       allowNext = enNext && (rtCfg[RT_UNLIMITED] || !fullNow);
    // counter only moves on attempts or explicit clear, never on delatch
    wire [4:0] countNext = retryCountClear ? 5'h00 :
                           (retryAttempt && allowNext && !fullNow) ? 5'(retryCount + 5'h01) :
                           retryCount;

    // ============================================================
    // registered outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lowLevel        <= LOW_LEVEL_HIGHEST;
            pwmDivider      <= DIV_SMALL;
            clockInternal   <= 1'b0;
            senseLowRatio   <= 1'b0;
            highWindow2     <= 1'b0;
            middleWindow2   <= 1'b0;
            motorWindowCode <= 2'h0;
            upperThrLow     <= 1'b0;
            middleThrLow    <= 1'b0;
            offsetAdd       <= 1'b0;
            retryPeriod     <= 2'h0;
            retryEnabled    <= 1'b0;
            retryAllowed    <= 1'b0;
            retryFull       <= 1'b0;
            retryCount      <= 5'h00;
            senseAvailable  <= 1'b0;
        end else begin
            lowLevel        <= lowNext;
            pwmDivider      <= ocCfg[OC_PRESCALE] ? DIV_LARGE : DIV_SMALL;
            clockInternal   <= ocCfg[OC_CLOCK_INT];
            senseLowRatio   <= ocCfg[OC_SENSE_RATIO];
            highWindow2     <= !isMotor && ocCfg[OC_HIGH_WIN];
            middleWindow2   <= !isMotor && ocCfg[OC_MID_WIN];
            motorWindowCode <= isMotor ? {ocCfg[OC_HIGH_WIN], ocCfg[OC_MID_WIN]} : 2'h0;
            upperThrLow     <= ocCfg[OC_UPPER_THR];
            middleThrLow    <= !isMotor && ocCfg[OC_MIDDLE_THR];
            offsetAdd       <= rtCfg[RT_OFFSET_POL];
            retryPeriod     <= {rtCfg[RT_PERIOD_HI], rtCfg[RT_PERIOD_LO]};
            retryEnabled    <= enNext;
            retryAllowed    <= allowNext;
            retryFull       <= (countNext >= RETRY_LIMIT);
            retryCount      <= countNext;
            senseAvailable  <= !ocWindowActive;
        end
    end

    // ============================================================
    // checks
    AST_SENSE_BLOCKED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ocWindowActive |=> !senseAvailable)
        else $error("sense available during overcurrent window");
    AST_RETRY_LIMIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fullNow && !retryCountClear) |=> (retryCount == RETRY_LIMIT))
        else $error("retry count passed limit");
    AST_COUNT_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!retryAttempt && !retryCountClear) |=> $stable(retryCount))
        else $error("retry count changed without attempt");
endmodule

// file: verilog/spc_config_bank.sv
// configuration register bank of the two-channel protected switch
`timescale 1ns/1ps
// Notes on behaviour
// - range bit 0 forces highest low threshold; else low bit picks middle or lowest
// - sensing of a channel unavailable while its own overcurrent window is active
// - prescale bit 1 divides external clock by 512, 0 by 256
// - clock source bit 1 uses internal clock, 0 external
// - sense ratio bit 1 low-current ratio, 0 high-current ratio
// - bulb: window bits pick high and middle times; motor: code picks one time
// - upper threshold bit 0 higher level, 1 lower level
// - middle threshold bit 0 higher, 1 lower; ignored for motor
// - offset polarity 1 adds offset, 0 subtracts it
// - two period bits pick one of four retry periods, default 00
// - unlimited bit allows endless retries, else stop after 16
// - retry count survives delatch and fault removal
// - retry bit: bulb 1 disables, motor 1 enables
// - both PWM enable bits start both channels together
// - parallel mode syncs channels and exposes bank 0 only
// - track-and-hold keeps sensed current after turn-off
// - watchdog disable bit 1 turns serial watchdog off
// - supply fail detect enabled enters fail-safe on low logic supply
// - sense select 00 off, 01 ch0, 10 ch1, 11 temp; sum in parallel high range
// - overvoltage disable bit 1 turns protection off
// - global register at code 0110, shared, bank bit ignored
// - word bit 13 selects bank: 0 channel 0, 1 channel 1
// - profile input 0 bulb, 1 motor, steers overcurrent and retry meaning
module spc_config_bank
    import spc_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // serial word write port
    input  wire logic        wrValid,
    input  wire logic [15:0] wrWord,
    // read-back port
    input  wire logic        rdReq,
    input  wire logic        rdBank,
    input  wire logic [2:0]  rdAddr,
    output logic             rdValid,
    output logic [8:0]       rdData,
    // channel status inputs
    input  wire logic [1:0]  loadProfileConfig,
    input  wire logic [1:0]  retryAttempt,
    input  wire logic [1:0]  retryCountClear,
    input  wire logic [1:0]  ocWindowActive,
    input  wire logic        logicSupplyLow,
    // per-channel decoded settings
    output logic [1:0]       lowLevel0,
    output logic [1:0]       lowLevel1,
    output logic [9:0]       pwmDivider0,
    output logic [9:0]       pwmDivider1,
    output logic [1:0]       clockInternal,
    output logic [1:0]       senseLowRatio,
    output logic [1:0]       highWindow2,
    output logic [1:0]       middleWindow2,
    output logic [1:0]       motorWindowCode0,
    output logic [1:0]       motorWindowCode1,
    output logic [1:0]       upperThrLow,
    output logic [1:0]       middleThrLow,
    output logic [1:0]       offsetAdd,
    output logic [1:0]       retryPeriod0,
    output logic [1:0]       retryPeriod1,
    output logic [1:0]       retryEnabled,
    output logic [1:0]       retryAllowed,
    output logic [1:0]       retryFull,
    output logic [1:0]       senseAvailable,
    // global settings
    output logic             pwmStartBoth,
    output logic             parallelMode,
    output logic             trackHoldEnable,
    output logic             watchdogEnable,
    output logic             failSafeRequest,
    output logic             overvoltageEnable,
    output spc_sense_t       senseSelect
);
    // ============================================================
    // storage
    logic [8:0] ocCfg_reg   [2];
    logic [8:0] rtCfg_reg   [2];
    logic [8:0] global_reg;
    logic [4:0] retryCount0;
    logic [4:0] retryCount1;

    // ============================================================
    // write decode
    wire       parallelOn = global_reg[GC_PARALLEL];
    wire [2:0] wrAddr     = wrWord[ADDR_MSB:ADDR_LSB];
    // in parallel mode only bank 0 exists for the host
    wire       wrBank     = wrWord[BANK_BIT] && !parallelOn;
    wire [8:0] wrData     = wrWord[DATA_W-1:0];
    wire       wrOc       = wrValid && (wrAddr == ADDR_OVERCURRENT);
    wire       wrRt       = wrValid && (wrAddr == ADDR_RETRY);
    wire       wrGlobal   = wrValid && (wrAddr == ADDR_GLOBAL);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ocCfg_reg[0] <= RESET_VALUE;
            ocCfg_reg[1] <= RESET_VALUE;
            rtCfg_reg[0] <= RESET_VALUE;
            rtCfg_reg[1] <= RESET_VALUE;
            global_reg   <= RESET_VALUE;
        end else begin
            if (wrOc) begin
                ocCfg_reg[wrBank] <= wrData;
            end
            if (wrRt) begin
                rtCfg_reg[wrBank] <= wrData;
            end
            if (wrGlobal) begin
                global_reg <= wrData;
            end
        end
    end

    // ============================================================
    // channel decode; channel 1 follows bank 0 in parallel mode
    wire [8:0] ocCh1 = parallelOn ? ocCfg_reg[0] : ocCfg_reg[1];
    wire [8:0] rtCh1 = parallelOn ? rtCfg_reg[0] : rtCfg_reg[1];
    wire       prof1 = parallelOn ? loadProfileConfig[0] : loadProfileConfig[1];

    spc_chan_decode uChan0 (
        .sys_clk         (sys_clk),
        .rst_n           (rst_n),
        .ocCfg           (ocCfg_reg[0]),
        .rtCfg           (rtCfg_reg[0]),
        .loadProfile     (loadProfileConfig[0]),
        .retryAttempt    (retryAttempt[0]),
        .retryCountClear (retryCountClear[0]),
        .ocWindowActive  (ocWindowActive[0]),
        .lowLevel        (lowLevel0),
        .pwmDivider      (pwmDivider0),
        .clockInternal   (clockInternal[0]),
        .senseLowRatio   (senseLowRatio[0]),
        .highWindow2     (highWindow2[0]),
        .middleWindow2   (middleWindow2[0]),
        .motorWindowCode (motorWindowCode0),
        .upperThrLow     (upperThrLow[0]),
        .middleThrLow    (middleThrLow[0]),
        .offsetAdd       (offsetAdd[0]),
        .retryPeriod     (retryPeriod0),
        .retryEnabled    (retryEnabled[0]),
        .retryAllowed    (retryAllowed[0]),
        .retryFull       (retryFull[0]),
        .retryCount      (retryCount0),
        .senseAvailable  (senseAvailable[0])
    );

    spc_chan_decode uChan1 (
        .sys_clk         (sys_clk),
        .rst_n           (rst_n),
        .ocCfg           (ocCh1),
        .rtCfg           (rtCh1),
        .loadProfile     (prof1),
        .retryAttempt    (retryAttempt[1]),
        .retryCountClear (retryCountClear[1]),
        .ocWindowActive  (ocWindowActive[1]),
        .lowLevel        (lowLevel1),
        .pwmDivider      (pwmDivider1),
        .clockInternal   (clockInternal[1]),
        .senseLowRatio   (senseLowRatio[1]),
        .highWindow2     (highWindow2[1]),
        .middleWindow2   (middleWindow2[1]),
        .motorWindowCode (motorWindowCode1),
        .upperThrLow     (upperThrLow[1]),
        .middleThrLow    (middleThrLow[1]),
        .offsetAdd       (offsetAdd[1]),
        .retryPeriod     (retryPeriod1),
        .retryEnabled    (retryEnabled[1]),
        .retryAllowed    (retryAllowed[1]),
        .retryFull       (retryFull[1]),
        .retryCount      (retryCount1),
        .senseAvailable  (senseAvailable[1])
    );

    // ============================================================
    // global decode
    wire [1:0] senseCode = {global_reg[GC_SENSE_SEL1], global_reg[GC_SENSE_SEL0]};
    // summed sensing only with the high range selected on bank 0
    wire       sumAllowed = ocCfg_reg[0][OC_HIGH_RANGE] && parallelOn;
    spc_sense_t senseNext;
    always_comb begin
        case (senseCode)
            2'h0:    senseNext = SENSE_OFF;
            2'h1:    senseNext = sumAllowed ? SENSE_SUM : SENSE_CH0;
            2'h2:    senseNext = SENSE_CH1;
            2'h3:    senseNext = SENSE_TEMP;
            default: senseNext = SENSE_OFF;
        endcase
    end
    wire       bothPwm   = global_reg[GC_PWM_EN1] && global_reg[GC_PWM_EN0];
    wire       failSafe  = global_reg[GC_SUPPLY_FAIL] && logicSupplyLow;

    // ============================================================
    // read-back
    wire       rdBankEff = rdBank && !parallelOn;
    wire [8:0] rtView0   = {rtCfg_reg[0][RT_OFFSET_POL], retryCount0[3:0], rtCfg_reg[0][3:0]};
    wire [8:0] rtView1   = {rtCh1[RT_OFFSET_POL], retryCount1[3:0], rtCh1[3:0]};
    wire [8:0] rdMux     = (rdAddr == ADDR_OVERCURRENT) ? (rdBankEff ? ocCfg_reg[1] : ocCfg_reg[0]) :
                           (rdAddr == ADDR_RETRY)       ? (rdBankEff ? rtView1 : rtView0) :
                           (rdAddr == ADDR_GLOBAL)      ? global_reg :
                           9'h000;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdValid           <= 1'b0;
            rdData            <= 9'h000;
            pwmStartBoth      <= 1'b0;
            parallelMode      <= 1'b0;
            trackHoldEnable   <= 1'b0;
            watchdogEnable    <= 1'b1;
            failSafeRequest   <= 1'b0;
            overvoltageEnable <= 1'b1;
            senseSelect       <= SENSE_OFF;
        end else begin
            rdValid           <= rdReq;
            rdData            <= rdReq ? rdMux : rdData;
            pwmStartBoth      <= bothPwm;
            parallelMode      <= parallelOn;
            trackHoldEnable   <= global_reg[GC_TRACK_HOLD];
            watchdogEnable    <= !global_reg[GC_WD_DISABLE];
            failSafeRequest   <= failSafe;
            overvoltageEnable <= !global_reg[GC_OV_DISABLE];
            senseSelect       <= senseNext;
        end
    end

    // ============================================================
    // checks
    AST_LOW_LEVEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!ocCfg_reg[0][OC_HIGH_RANGE]) |=> (lowLevel0 == LOW_LEVEL_HIGHEST))
        else $error("low threshold not highest with range bit clear");
    AST_PRESCALE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ocCfg_reg[0][OC_PRESCALE] |=> (pwmDivider0 == DIV_LARGE))
        else $error("prescale divider wrong");
    AST_PWM_BOTH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wrGlobal && wrData[GC_PWM_EN1] && wrData[GC_PWM_EN0]) |=> ##1 pwmStartBoth)
        else $error("pwm start not raised two cycles after write");
    AST_GLOBAL_SHARED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wrGlobal |=> (global_reg == $past(wrData)))
        else $error("global register not written regardless of bank");
    AST_BANK_SELECT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wrOc && wrWord[BANK_BIT] && !parallelOn) |=> $stable(ocCfg_reg[0]))
        else $error("bank 1 write touched bank 0");
    AST_WATCHDOG: assert property (@(posedge sys_clk) disable iff (!rst_n)
        global_reg[GC_WD_DISABLE] |=> !watchdogEnable)
        else $error("watchdog still enabled");
    AST_SENSE_SUM: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (senseCode == 2'h1 && sumAllowed) |=> (senseSelect == SENSE_SUM))
        else $error("summed sensing not selected");
    AST_READ_LATENCY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rdReq && parallelOn && rdAddr == ADDR_OVERCURRENT) |=> (rdValid && rdData == $past(ocCfg_reg[0])))
        else $error("parallel read did not return bank 0");
endmodule

// file: verilog/spc_pkg.sv
// constants for the switch protection configuration register bank
package spc_pkg;
    // ============================================================
    // serial word layout
    localparam int BANK_BIT      = 13;
    localparam int ADDR_MSB      = 12;
    localparam int ADDR_LSB      = 10;
    localparam int DATA_W        = 9;
    // ============================================================
    // register address codes (bits 12:10 of the word)
    localparam logic [2:0] ADDR_OVERCURRENT = 3'h4;
    localparam logic [2:0] ADDR_RETRY       = 3'h5;
    localparam logic [2:0] ADDR_GLOBAL      = 3'h6;
    localparam logic [8:0] RESET_VALUE      = 9'h000;
    // ============================================================
    // overcurrent_config fields
    localparam int OC_HIGH_RANGE  = 8;
    localparam int OC_PRESCALE    = 7;
    localparam int OC_CLOCK_INT   = 6;
    localparam int OC_SENSE_RATIO = 5;
    localparam int OC_HIGH_WIN    = 4;
    localparam int OC_MID_WIN     = 3;
    localparam int OC_UPPER_THR   = 2;
    localparam int OC_MIDDLE_THR  = 1;
    localparam int OC_LOW_THR     = 0;
    // ============================================================
    // retry_config fields
    localparam int RT_OFFSET_POL  = 8;
    localparam int RT_COUNT_MSB   = 7;
    localparam int RT_COUNT_LSB   = 4;
    localparam int RT_PERIOD_HI   = 3;
    localparam int RT_PERIOD_LO   = 2;
    localparam int RT_UNLIMITED   = 1;
    localparam int RT_CONTROL     = 0;
    // ============================================================
    // global_config fields
    localparam int GC_PWM_EN1     = 8;
    localparam int GC_PWM_EN0     = 7;
    localparam int GC_PARALLEL    = 6;
    localparam int GC_TRACK_HOLD  = 5;
    localparam int GC_WD_DISABLE  = 4;
    localparam int GC_SUPPLY_FAIL = 3;
    localparam int GC_SENSE_SEL1  = 2;
    localparam int GC_SENSE_SEL0  = 1;
    localparam int GC_OV_DISABLE  = 0;
    // ============================================================
    // decoded levels and limits
    localparam logic [1:0] LOW_LEVEL_HIGHEST = 2'h0;
    localparam logic [1:0] LOW_LEVEL_MIDDLE  = 2'h1;
    localparam logic [1:0] LOW_LEVEL_LOWEST  = 2'h2;
    localparam logic [9:0] DIV_SMALL         = 10'h100;
    localparam logic [9:0] DIV_LARGE         = 10'h200;
    localparam logic [4:0] RETRY_LIMIT       = 5'h10;
    localparam logic       PROFILE_BULB      = 1'b0;
    localparam logic       PROFILE_MOTOR     = 1'b1;

    typedef enum logic [4:0] {
        SENSE_OFF  = 5'h01,
        SENSE_CH0  = 5'h02,
        SENSE_CH1  = 5'h04,
        SENSE_TEMP = 5'h08,
        SENSE_SUM  = 5'h10
    } spc_sense_t;
endpackage
